//--- power_mode_supply_controller.sv
// Power mode sequencer, regulator selection, buck converter and supply monitors
//
// How it works
// - Intelligent bypass forces the buck converter into bypass below the brown-out level.
// - Every reset brings the buck converter up in bypass.
// - Software enable or bypass of the buck converter takes effect at once.
// - A control bit picks automatic bypass; the level comes from option settings.
// - Main regulator powers the core in Run, Sleep and shallowest Stop.
// - Low-power regulator serves LP run, LP sleep, deeper Stops, retained SRAM Standby.
// - Standby and Shutdown power the main regulator down, outputs high impedance; the LP regulator stays on in retained SRAM Standby.
// - The radio subsystem alone switches the radio regulator.
// - LP run: main regulator off, CPU clock at most 2 MHz.
// - Outside Shutdown, reset is held while supply sits below the brown-out level.
// - Power-on uses the lowest brown-out level; higher ones only via options.
// - Enabled supply detector interrupts on falling, rising or both crossings.
// - Analog supply is compared with a fixed level and reported as in range.
// - After reset the mode is Run with voltage range 1.
// - Sleep stops only the application CPU; any interrupt or event wakes it.
// - LP sleep only from LP run, gates CPU clock, wakes back to LP run.
// - Stop modes keep SRAM, registers and slow oscillator alive.
// - Shallowest Stop keeps the main regulator on for fast wakeup.
// - Stop exit uses multispeed or 16 MHz clock; converter restarts automatically.
`timescale 1ns/1ns
`default_nettype none
module power_mode_supply_controller
  import pwr_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // Software control bits
  input wire logic i_buck_converter_enable,
  input wire logic i_intelligent_bypass_en,
  input wire logic i_range_select,
  input wire logic [2:0] i_mode_request,
  input wire logic i_wake_clk_fast,
  input wire logic i_retain_sram_standby,
  input wire logic i_shutdown_request,
  input wire logic i_wakeup_event,
  input wire logic [15:0] i_sys_clk_khz,
  input wire logic [15:0] i_periph_clk_khz,
  input wire logic i_radio_active,
  // Option settings
  input wire logic [1:0] i_brownout_level_option,
  input wire logic i_options_loaded,
  // Programmable supply detector
  input wire logic i_supply_detector_enable,
  input wire logic i_detect_falling_en,
  input wire logic i_detect_rising_en,
  input wire logic i_supply_detector_below,
  input wire logic i_supply_detector_ack,
  // Analog comparators
  input wire logic i_brownout_monitor_below,
  input wire logic i_analog_supply_monitor_ok,
  // Radio subsystem request for its regulator
  input wire logic i_radio_regulator_request,
  // Regulator and converter controls
  output logic O_BUCK_CONVERTER_ACTIVE,
  output logic O_MAIN_REGULATOR_ON,
  output logic O_LOW_POWER_REGULATOR_ON,
  output logic O_REGULATOR_HIGHZ,
  output logic O_RADIO_REGULATOR_ON,
  output logic O_RETAINED_SRAM_BANK_SUPPLY,
  // Clocks and resets
  output logic O_APPLICATION_CPU_CLK_EN,
  output logic O_SLOW_OSC_KEEP,
  output logic O_WAKE_CLK_FAST,
  output logic O_SYSTEM_RESET_HOLD,
  output logic [1:0] O_BROWNOUT_LEVEL,
  // Status
  output logic [3:0] O_POWER_MODE,
  output logic O_CORE_SUPPLY_RANGE,
  output logic O_CLOCK_LIMIT_ERROR,
  output logic O_SUPPLY_DETECTOR_IRQ,
  output logic O_ANALOG_SUPPLY_OK
);

  power_mode_e mode_q;
  power_mode_e mode_d;
  logic buck_q;
  logic main_reg_q;
  logic lp_reg_q;
  logic highz_q;
  logic radio_reg_q;
  logic sram_ret_q;
  logic cpu_clk_en_q;
  logic slow_osc_q;
  logic wake_fast_q;
  logic hold_q;
  logic [1:0] brownout_level_q;
  logic range_q;
  logic limit_err_q;
  logic det_irq_q;
  logic analog_ok_q;
  logic opt_done_q;
  logic brownout_below;
  logic det_rise;
  logic det_fall;
  logic analog_ok;
  logic radio_req_meta_q;
  logic radio_req_q;
  logic in_stop;

  // Comparators are asynchronous to the system clock
  supply_filter u_brownout_filter (
    .clk(I_CLOCK),
    .rst(I_RST),
    .i_raw(i_brownout_monitor_below),
    .o_level(brownout_below),
    .o_rise(),
    .o_fall()
  );
  supply_filter u_detector_filter (
    .clk(I_CLOCK),
    .rst(I_RST),
    .i_raw(i_supply_detector_below),
    .o_level(),
    .o_rise(det_rise),
    .o_fall(det_fall)
  );
  supply_filter u_analog_filter (
    .clk(I_CLOCK),
    .rst(I_RST),
    .i_raw(i_analog_supply_monitor_ok),
    .o_level(analog_ok),
    .o_rise(),
    .o_fall()
  );

  function automatic logic is_stop(input power_mode_e m);
    is_stop = (m == MODE_STOP0) || (m == MODE_STOP1) || (m == MODE_STOP2);
  endfunction : is_stop
  assign in_stop = is_stop(mode_q);

  // Mode sequencer
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN:
      begin
        if (i_shutdown_request)
          mode_d = MODE_SHUTDOWN;
        else
        begin
          case (i_mode_request)
            REQ_SLEEP: mode_d = MODE_SLEEP;
            REQ_LP_RUN: mode_d = MODE_LP_RUN;
            REQ_STOP0: mode_d = MODE_STOP0;
            REQ_STOP1: mode_d = MODE_STOP1;
            REQ_STOP2: mode_d = MODE_STOP2;
            REQ_STANDBY: mode_d = MODE_STANDBY;
            default: mode_d = MODE_RUN;
          endcase
        end
      end
      MODE_SLEEP, MODE_STOP0, MODE_STOP1, MODE_STOP2:
      begin
        if (i_wakeup_event)
          mode_d = MODE_RUN;
      end
      MODE_LP_RUN:
      begin
        if (i_mode_request == REQ_SLEEP)
          mode_d = MODE_LP_SLEEP;
        else if (i_mode_request == REQ_RUN)
          mode_d = MODE_RUN;
        else if (i_mode_request == REQ_STOP1)
          mode_d = MODE_STOP1;
        else if (i_mode_request == REQ_STOP2)
          mode_d = MODE_STOP2;
      end
      MODE_LP_SLEEP:
      begin
        if (i_wakeup_event)
          mode_d = MODE_LP_RUN;
      end
      // Leaving these modes goes through a full reset
      MODE_STANDBY, MODE_SHUTDOWN: mode_d = mode_q;
      default: mode_d = MODE_RUN;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      mode_q <= MODE_RUN;
    else
      mode_q <= mode_d;
  end

  // Regulator selection follows the next mode so it changes with the mode
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      main_reg_q <= 1'b1;
      lp_reg_q <= 1'b0;
      highz_q <= 1'b0;
      sram_ret_q <= 1'b0;
    end
    else
    begin
      main_reg_q <= (mode_d == MODE_RUN) || (mode_d == MODE_SLEEP)
                    || (mode_d == MODE_STOP0);
      lp_reg_q <= (mode_d == MODE_LP_RUN) || (mode_d == MODE_LP_SLEEP)
                  || (mode_d == MODE_STOP1) || (mode_d == MODE_STOP2)
                  || ((mode_d == MODE_STANDBY) && i_retain_sram_standby);
      highz_q <= (mode_d == MODE_SHUTDOWN) || (mode_d == MODE_STANDBY);
      sram_ret_q <= (mode_d != MODE_SHUTDOWN)
                    && ((mode_d != MODE_STANDBY) || i_retain_sram_standby);
    end
  end

  // Clock gating: only the application CPU stops in the sleep modes
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cpu_clk_en_q <= 1'b1;
      slow_osc_q <= 1'b1;
    end
    else
    begin
      cpu_clk_en_q <= (mode_d == MODE_RUN) || (mode_d == MODE_LP_RUN);
      slow_osc_q <= (mode_d != MODE_SHUTDOWN);
    end
  end

  // Wakeup clock choice; the fast oscillator is forced while radio or converter is used
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      wake_fast_q <= WAKE_CLK_FAST_RST;
    else if (!in_stop)
      wake_fast_q <= i_wake_clk_fast || i_radio_active || i_buck_converter_enable;
  end

  // Buck converter: bypass at reset, in bypass below brown-out when selected
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      buck_q <= BUCK_ACTIVE_RST;
    else if (i_intelligent_bypass_en && brownout_below)
      buck_q <= 1'b0;
    else if (in_stop && (mode_d == MODE_RUN))
      buck_q <= i_buck_converter_enable;
    else
      buck_q <= i_buck_converter_enable && !in_stop
                && (mode_d != MODE_STANDBY) && (mode_d != MODE_SHUTDOWN);
  end

  // Radio regulator follows the radio subsystem alone
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      radio_req_meta_q <= 1'b0;
      radio_req_q <= 1'b0;
      radio_reg_q <= 1'b0;
    end
    else
    begin
      radio_req_meta_q <= i_radio_regulator_request;
      radio_req_q <= radio_req_meta_q;
      radio_reg_q <= radio_req_q;
    end
  end

  // Brown-out level: lowest after reset, option value only once options are loaded
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      brownout_level_q <= BROWNOUT_LEVEL_LOWEST;
      opt_done_q <= 1'b0;
    end
    else if (i_options_loaded && !opt_done_q)
    begin
      brownout_level_q <= i_brownout_level_option;
      opt_done_q <= 1'b1;
    end
  end

  // Reset hold while supply is low; the monitor is off in Shutdown
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      hold_q <= 1'b1;
    else
      hold_q <= brownout_below && (mode_q != MODE_SHUTDOWN);
  end

  // Voltage range, only changed in Run
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      range_q <= RANGE_1;
    else if (mode_q == MODE_RUN)
      range_q <= i_range_select;
  end

  // Clock limit check flags software that breaks the range limits
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      limit_err_q <= 1'b0;
    else
    begin
      case (mode_q)
        MODE_LP_RUN, MODE_LP_SLEEP:
          limit_err_q <= (32'(i_sys_clk_khz) > LP_RUN_MAX_KHZ)
                         || i_radio_active;
        default:
          if (range_q == RANGE_2)
            limit_err_q <= (32'(i_sys_clk_khz) > RANGE2_MAX_KHZ)
                           || (32'(i_periph_clk_khz) > RANGE2_MAX_KHZ);
          else
            limit_err_q <= 32'(i_sys_clk_khz) > RANGE1_MAX_KHZ;
      endcase
    end
  end

  // Detector interrupt; a new crossing wins over the acknowledge
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      det_irq_q <= 1'b0;
    else if (i_supply_detector_enable && mode_q != MODE_STANDBY && mode_q != MODE_SHUTDOWN
             && ((det_rise && i_detect_falling_en) || (det_fall && i_detect_rising_en)))
      det_irq_q <= 1'b1;
    else if (i_supply_detector_ack || !i_supply_detector_enable)
      det_irq_q <= 1'b0;
  end

  // Analog supply status
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
      analog_ok_q <= 1'b0;
    else
      analog_ok_q <= analog_ok;
  end

  assign O_BUCK_CONVERTER_ACTIVE = buck_q;
  assign O_MAIN_REGULATOR_ON = main_reg_q;
  assign O_LOW_POWER_REGULATOR_ON = lp_reg_q;
  assign O_REGULATOR_HIGHZ = highz_q;
  assign O_RADIO_REGULATOR_ON = radio_reg_q;
  assign O_RETAINED_SRAM_BANK_SUPPLY = sram_ret_q;
  assign O_APPLICATION_CPU_CLK_EN = cpu_clk_en_q;
  assign O_SLOW_OSC_KEEP = slow_osc_q;
  assign O_WAKE_CLK_FAST = wake_fast_q;
  assign O_SYSTEM_RESET_HOLD = hold_q;
  assign O_BROWNOUT_LEVEL = brownout_level_q;
  assign O_POWER_MODE = mode_q;
  assign O_CORE_SUPPLY_RANGE = range_q;
  assign O_CLOCK_LIMIT_ERROR = limit_err_q;
  assign O_SUPPLY_DETECTOR_IRQ = det_irq_q;
  assign O_ANALOG_SUPPLY_OK = analog_ok_q;

endmodule : power_mode_supply_controller
`default_nettype wire

//--- pwr_ctrl_assertions.sv
// Property checker for the power mode and supply controller
`timescale 1ns/1ns
`default_nettype none
module pwr_ctrl_assertions
  import pwr_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // Inputs watched
  input wire logic i_buck_converter_enable,
  input wire logic i_intelligent_bypass_en,
  input wire logic [2:0] i_mode_request,
  input wire logic i_shutdown_request,
  input wire logic i_options_loaded,
  input wire logic i_supply_detector_enable,
  input wire logic i_brownout_monitor_below,
  input wire logic i_radio_regulator_request,
  // Outputs watched
  input wire logic O_BUCK_CONVERTER_ACTIVE,
  input wire logic O_MAIN_REGULATOR_ON,
  input wire logic O_LOW_POWER_REGULATOR_ON,
  input wire logic O_REGULATOR_HIGHZ,
  input wire logic O_RADIO_REGULATOR_ON,
  input wire logic O_APPLICATION_CPU_CLK_EN,
  input wire logic O_SLOW_OSC_KEEP,
  input wire logic O_SYSTEM_RESET_HOLD,
  input wire logic [1:0] O_BROWNOUT_LEVEL,
  input wire logic [3:0] O_POWER_MODE,
  input wire logic O_SUPPLY_DETECTOR_IRQ
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  logic [3:0] low_cnt_q;
  logic loaded_q;
  // Margin over the settle filter so only a settled brown-out counts
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST) low_cnt_q <= 4'h0;
    else if (!i_brownout_monitor_below) low_cnt_q <= 4'h0;
    else if (low_cnt_q != 4'hF) low_cnt_q <= low_cnt_q + 4'h1;
  end
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST) loaded_q <= 1'b0;
    else if (i_options_loaded) loaded_q <= 1'b1;
  end
  a_sleep_gate: assert property (
    (O_POWER_MODE == MODE_RUN && i_mode_request == REQ_SLEEP && !i_shutdown_request)
    |=> (O_POWER_MODE == MODE_SLEEP && !O_APPLICATION_CPU_CLK_EN)) else $error("bad sleep");
  a_main_reg_modes: assert property (
    (O_POWER_MODE inside {MODE_RUN, MODE_SLEEP, MODE_STOP0}) |-> O_MAIN_REGULATOR_ON)
    else $error("main regulator off");
  a_lp_reg_modes: assert property (
    (O_POWER_MODE inside {MODE_LP_RUN, MODE_LP_SLEEP, MODE_STOP1, MODE_STOP2})
    |-> (O_LOW_POWER_REGULATOR_ON && !O_MAIN_REGULATOR_ON)) else $error("bad lp regulator");
  a_standby_off: assert property (
    (O_POWER_MODE inside {MODE_STANDBY, MODE_SHUTDOWN})
    |-> (O_REGULATOR_HIGHZ && !O_MAIN_REGULATOR_ON)) else $error("regulator not off");
  a_stop_slow_osc: assert property (
    (O_POWER_MODE inside {MODE_STOP0, MODE_STOP1, MODE_STOP2}) |-> O_SLOW_OSC_KEEP)
    else $error("slow osc dropped");
  a_lp_sleep_from: assert property (
    (O_POWER_MODE == MODE_LP_SLEEP && $past(O_POWER_MODE) != MODE_LP_SLEEP)
    |-> $past(O_POWER_MODE) == MODE_LP_RUN) else $error("lp sleep bad origin");
  a_buck_bypass: assert property (
    !i_buck_converter_enable |=> !O_BUCK_CONVERTER_ACTIVE) else $error("buck not bypassed");
  a_buck_follow: assert property (
    (O_POWER_MODE == MODE_RUN && i_buck_converter_enable && !i_intelligent_bypass_en
    && i_mode_request == REQ_NONE && !i_shutdown_request) |=> O_BUCK_CONVERTER_ACTIVE)
    else $error("buck not converting");
  a_auto_bypass: assert property (
    (low_cnt_q >= 4'hE && i_intelligent_bypass_en) |=> !O_BUCK_CONVERTER_ACTIVE)
    else $error("no auto bypass");
  a_brownout_hold: assert property (
    (low_cnt_q >= 4'hE && O_POWER_MODE != MODE_SHUTDOWN) |-> O_SYSTEM_RESET_HOLD)
    else $error("reset not held");
  a_lowest_level: assert property (
    !loaded_q |-> O_BROWNOUT_LEVEL == BROWNOUT_LEVEL_LOWEST)
    else $error("brown-out level not lowest");
  a_irq_disable: assert property (
    !i_supply_detector_enable |=> !O_SUPPLY_DETECTOR_IRQ) else $error("irq while disabled");
  a_radio_reg: assert property (
    $rose(i_radio_regulator_request) |-> ##[1:5] O_RADIO_REGULATOR_ON)
    else $error("radio regulator late");
endmodule : pwr_ctrl_assertions
bind power_mode_supply_controller pwr_ctrl_assertions pwr_ctrl_assertions_inst (
  .I_CLOCK, .I_RST, .i_buck_converter_enable, .i_intelligent_bypass_en, .i_mode_request,
  .i_shutdown_request, .i_options_loaded, .i_supply_detector_enable,
  .i_brownout_monitor_below, .i_radio_regulator_request, .O_BUCK_CONVERTER_ACTIVE,
  .O_MAIN_REGULATOR_ON, .O_LOW_POWER_REGULATOR_ON, .O_REGULATOR_HIGHZ,
  .O_RADIO_REGULATOR_ON, .O_APPLICATION_CPU_CLK_EN, .O_SLOW_OSC_KEEP,
  .O_SYSTEM_RESET_HOLD, .O_BROWNOUT_LEVEL, .O_POWER_MODE, .O_SUPPLY_DETECTOR_IRQ);
`default_nettype wire

//--- pwr_ctrl_pkg.sv
// Constants and types shared by the power mode and supply controller
package pwr_ctrl_pkg;

  // Power modes held by the mode state register
  typedef enum logic [3:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_LP_RUN,
    MODE_LP_SLEEP,
    MODE_STOP0,
    MODE_STOP1,
    MODE_STOP2,
    MODE_STANDBY,
    MODE_SHUTDOWN
  } power_mode_e;

  // Mode requests from software
  localparam logic [2:0] REQ_NONE = 3'h0;
  localparam logic [2:0] REQ_SLEEP = 3'h1;
  localparam logic [2:0] REQ_LP_RUN = 3'h2;
  localparam logic [2:0] REQ_RUN = 3'h3;
  localparam logic [2:0] REQ_STOP0 = 3'h4;
  localparam logic [2:0] REQ_STOP1 = 3'h5;
  localparam logic [2:0] REQ_STOP2 = 3'h6;
  localparam logic [2:0] REQ_STANDBY = 3'h7;

  // Voltage range codes
  localparam logic RANGE_1 = 1'b0;
  localparam logic RANGE_2 = 1'b1;

  // Brown-out threshold option codes; code 0 is the lowest level, 1710 mV
  localparam logic [1:0] BROWNOUT_LEVEL_LOWEST = 2'h0;
  localparam int BROWNOUT_LOWEST_MV = 1710;

  // Frequency limits, in kHz
  localparam int RANGE1_MAX_KHZ = 64000;
  localparam int RANGE2_MAX_KHZ = 16000;
  localparam int LP_RUN_MAX_KHZ = 2000;
  localparam int FAST_OSC_KHZ = 16000;
  localparam int MULTISPEED_MAX_KHZ = 48000;

  // Clock and settle time of the supply monitor inputs
  localparam int CLK_MHZ = 125;
  localparam int MON_SETTLE_NS = 64;
  localparam int MON_SETTLE_CYC = (MON_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] MON_SETTLE_CNT = 4'(MON_SETTLE_CYC);

  // Reset values
  localparam logic BUCK_ACTIVE_RST = 1'b0;
  localparam logic WAKE_CLK_FAST_RST = 1'b1;

endpackage : pwr_ctrl_pkg

//--- supply_filter.sv
// Two-flop synchroniser with settle filter for one analog comparator output
`timescale 1ns/1ns
`default_nettype none
module supply_filter
  import pwr_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic i_raw,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic meta_q;
  logic sync_q;
  logic level_q;
  logic [3:0] cnt_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_raw;
      sync_q <= meta_q;
    end
  end

  // Comparator chatter near the threshold would fire repeated events
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 4'h0;
      level_q <= 1'b0;
    end
    else if (sync_q == level_q)
    begin
      cnt_q <= 4'h0;
    end
    else if (cnt_q >= MON_SETTLE_CNT - 4'h1)
    begin
      cnt_q <= 4'h0;
      level_q <= sync_q;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign o_level = level_q;
  assign o_rise = (sync_q != level_q) && (cnt_q >= MON_SETTLE_CNT - 4'h1) && sync_q;
  assign o_fall = (sync_q != level_q) && (cnt_q >= MON_SETTLE_CNT - 4'h1) && !sync_q;

endmodule : supply_filter
`default_nettype wire

//--- supply_monitor_model.sv
// Behavioural analog comparators and radio subsystem beside the controller
`timescale 1ns/1ns
`default_nettype none
module supply_monitor_model (
  // Supply conditions set by the bench
  input wire logic i_vdd_low,
  input wire logic i_vdd_below_detect,
  input wire logic i_analog_good,
  input wire logic i_radio_busy,
  // Comparator and radio lines
  output logic o_brownout_below,
  output logic o_detector_below,
  output logic o_analog_ok,
  output logic o_radio_request
);
  // Analog delay keeps the comparator edges unrelated to the clock
  assign #3 o_brownout_below = i_vdd_low;
  assign #3 o_detector_below = i_vdd_below_detect;
  assign #3 o_analog_ok = i_analog_good;
  assign #3 o_radio_request = i_radio_busy;
endmodule : supply_monitor_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the power mode and supply controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pwr_ctrl_pkg::*;
  logic clk, rst, buck_en, auto_byp, range_sel, wake_fast, retain, shut_req, wake;
  logic radio_busy, opt_loaded, det_en, fall_en, rise_en, det_ack, vdd_low, vdd_det, ana_good;
  logic bo_below, det_below, ana_ok, radio_req;
  logic buck, main_on, lp_on, highz, radio_on, sram_on, cpu_en, slow_on, wfast, hold;
  logic rng, lim, irq, aok;
  logic [2:0] mode_req;
  logic [15:0] sys_khz, per_khz;
  logic [1:0] bo_opt, bo_lvl;
  logic [3:0] mode;
  int bad_count = 0;
  int cmp_count = 0;
  power_mode_supply_controller power_mode_supply_controller_inst (
    .I_CLOCK(clk), .I_RST(rst), .i_buck_converter_enable(buck_en),
    .i_intelligent_bypass_en(auto_byp), .i_range_select(range_sel), .i_mode_request(mode_req),
    .i_wake_clk_fast(wake_fast), .i_retain_sram_standby(retain), .i_shutdown_request(shut_req),
    .i_wakeup_event(wake), .i_sys_clk_khz(sys_khz), .i_periph_clk_khz(per_khz),
    .i_radio_active(radio_busy), .i_brownout_level_option(bo_opt),
    .i_options_loaded(opt_loaded),
    .i_supply_detector_enable(det_en), .i_detect_falling_en(fall_en),
    .i_detect_rising_en(rise_en), .i_supply_detector_below(det_below),
    .i_supply_detector_ack(det_ack), .i_brownout_monitor_below(bo_below),
    .i_analog_supply_monitor_ok(ana_ok), .i_radio_regulator_request(radio_req),
    .O_BUCK_CONVERTER_ACTIVE(buck), .O_MAIN_REGULATOR_ON(main_on),
    .O_LOW_POWER_REGULATOR_ON(lp_on), .O_REGULATOR_HIGHZ(highz),
    .O_RADIO_REGULATOR_ON(radio_on), .O_RETAINED_SRAM_BANK_SUPPLY(sram_on),
    .O_APPLICATION_CPU_CLK_EN(cpu_en), .O_SLOW_OSC_KEEP(slow_on), .O_WAKE_CLK_FAST(wfast),
    .O_SYSTEM_RESET_HOLD(hold), .O_BROWNOUT_LEVEL(bo_lvl), .O_POWER_MODE(mode),
    .O_CORE_SUPPLY_RANGE(rng), .O_CLOCK_LIMIT_ERROR(lim), .O_SUPPLY_DETECTOR_IRQ(irq),
    .O_ANALOG_SUPPLY_OK(aok));
  supply_monitor_model supply_monitor_model_inst (
    .i_vdd_low(vdd_low), .i_vdd_below_detect(vdd_det), .i_analog_good(ana_good),
    .i_radio_busy(radio_busy), .o_brownout_below(bo_below), .o_detector_below(det_below),
    .o_analog_ok(ana_ok), .o_radio_request(radio_req));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait that also compares; a level never reached ends the run
  task automatic wait_on(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) cyc(1);
    chk(s, v);
    if (s !== v) results();
  endtask : wait_on
  task automatic req(input logic [2:0] code);
    mode_req = code;
    cyc(1);
    mode_req = REQ_NONE;
    cyc(1);
  endtask : req
  task automatic wake_up();
    wake = 1'b1;
    cyc(1);
    wake = 1'b0;
  endtask : wake_up
  task automatic do_reset();
    rst = 1'b1;
    cyc(10);
    rst = 1'b0;
  endtask : do_reset
  initial
  begin
    {rst, buck_en, auto_byp, range_sel, wake_fast, retain, shut_req, wake} = 8'h84;
    {radio_busy, opt_loaded, det_en, fall_en, rise_en, det_ack} = 6'h00;
    {vdd_low, vdd_det, ana_good} = 3'h0;
    mode_req = REQ_NONE;
    sys_khz = 16'h3E80;
    per_khz = 16'h3E80;
    bo_opt = 2'h2;
    do_reset();
    chk(buck, BUCK_ACTIVE_RST);
    chk({mode, rng}, {MODE_RUN, RANGE_1});
    chk({main_on, lp_on, highz}, 3'h4);
    cyc(3);
    chk({bo_lvl, wfast}, {BROWNOUT_LEVEL_LOWEST, 1'b0});
    opt_loaded = 1'b1;
    cyc(2);
    chk(bo_lvl, 2'h2);
    buck_en = 1'b1;
    cyc(1);
    chk(buck, 1'b1);
    buck_en = 1'b0;
    cyc(1);
    chk(buck, 1'b0);
    $display("Test reset and buck done");
    range_sel = RANGE_2;
    sys_khz = 16'h4E20;
    cyc(3);
    chk({rng, lim}, 2'h3);
    sys_khz = 16'h3E80;
    cyc(3);
    chk(lim, 1'b0);
    per_khz = 16'h4E20;
    cyc(1);
    chk(lim, 1'b1);
    per_khz = 16'h3E80;
    range_sel = RANGE_1;
    sys_khz = 16'hFA00;
    cyc(3);
    chk({rng, lim}, 2'h0);
    $display("Test ranges done");
    req(REQ_SLEEP);
    chk({mode, cpu_en, main_on}, {MODE_SLEEP, 2'h1});
    wake_up();
    chk({mode, cpu_en}, {MODE_RUN, 1'b1});
    sys_khz = 16'h07D0;
    req(REQ_LP_RUN);
    chk({mode, main_on, lp_on, lim}, {MODE_LP_RUN, 3'h2});
    radio_busy = 1'b1;
    cyc(1);
    chk(lim, 1'b1);
    radio_busy = 1'b0;
    cyc(1);
    req(REQ_SLEEP);
    chk({mode, cpu_en, lp_on}, {MODE_LP_SLEEP, 2'h1});
    wake_up();
    chk(mode, MODE_LP_RUN);
    req(REQ_STOP0);
    chk(mode, MODE_LP_RUN);
    req(REQ_RUN);
    chk({mode, main_on}, {MODE_RUN, 1'b1});
    $display("Test sleep and low-power run done");
    buck_en = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      req(REQ_STOP0 + 3'(k));
      chk({mode, slow_on, buck, wfast}, {4'(MODE_STOP0) + 4'(k), 3'h5});
      chk({main_on, lp_on}, (k == 0) ? 2'h2 : 2'h1);
      wake_up();
      chk(mode, MODE_RUN);
      cyc(1);
      chk(buck, 1'b1);
    end
    $display("Test stop modes done");
    auto_byp = 1'b1;
    vdd_low = 1'b1;
    wait_on(hold, 1'b1);
    cyc(4);
    chk(buck, 1'b0);
    vdd_low = 1'b0;
    wait_on(hold, 1'b0);
    auto_byp = 1'b0;
    vdd_low = 1'b1;
    cyc(16);
    chk({hold, buck}, 2'h3);
    vdd_low = 1'b0;
    wait_on(hold, 1'b0);
    $display("Test brown-out done");
    {det_en, fall_en} = 2'h3;
    vdd_det = 1'b1;
    wait_on(irq, 1'b1);
    det_ack = 1'b1;
    cyc(1);
    det_ack = 1'b0;
    cyc(1);
    chk(irq, 1'b0);
    {fall_en, rise_en} = 2'h1;
    vdd_det = 1'b0;
    wait_on(irq, 1'b1);
    det_en = 1'b0;
    cyc(2);
    chk(irq, 1'b0);
    ana_good = 1'b1;
    wait_on(aok, 1'b1);
    ana_good = 1'b0;
    wait_on(aok, 1'b0);
    radio_busy = 1'b1;
    wait_on(radio_on, 1'b1);
    radio_busy = 1'b0;
    wait_on(radio_on, 1'b0);
    $display("Test monitors done");
    req(REQ_STANDBY);
    chk({mode, highz, main_on, sram_on, lp_on}, {MODE_STANDBY, 4'hB});
    wake_up();
    chk(mode, MODE_STANDBY);
    do_reset();
    chk(buck, BUCK_ACTIVE_RST);
    cyc(1);
    shut_req = 1'b1;
    cyc(1);
    shut_req = 1'b0;
    cyc(1);
    chk({mode, highz}, {MODE_SHUTDOWN, 1'b1});
    $display("Test standby and shutdown done");
    results();
  end
endmodule : tb
`default_nettype wire
